// ===== core/arbc_exec.sv
// Purpose: decode and execute the and_acc_with_reg and single_bit_reset_op instructions
// Assumes: file memory answers file_rd_data in the same cycle file_rd_en is high
// Notes:   one instruction per four-cycle instruction cycle, writes land in q4
//          the accumulator and the zero flag live outside; this block only issues
//          write strobes for them, so the core owns their storage and reset values
//          words that match neither pattern run as a silent no-op: no read, no write
//          the first q1 after reset decodes with instr_ready still low, so a core
//          must hold instr_valid low until it sees instr_ready
`timescale 1ns/1ps
`default_nettype none
module arbc_exec (
   input  wire logic                     ref_clk,
   input  wire logic                     reset_n,
   input  wire logic                     instr_valid,
   input  wire logic [arbc_pkg::IW-1:0]  instr_word,
   input  wire logic [arbc_pkg::DW-1:0]  acc_in,
   input  wire logic [arbc_pkg::DW-1:0]  file_rd_data,
   output var  logic                     instr_ready,
   output var  logic                     file_rd_en,
   output var  logic [arbc_pkg::AW-1:0]  file_rd_addr,
   output var  logic                     file_wr_en,
   output var  logic [arbc_pkg::AW-1:0]  file_wr_addr,
   output var  logic [arbc_pkg::DW-1:0]  file_wr_data,
   output var  logic                     acc_wr_en,
   output var  logic [arbc_pkg::DW-1:0]  acc_wr_data,
   output var  logic                     zero_wr_en,
   output var  logic                     zero_value
);
   arbc_phase_if ph ();

   // phase sequencer
   arbc_qphase u_qphase (
      .ref_clk (ref_clk),
      .reset_n (reset_n),
      .ph      (ph)
   );

   typedef struct packed {
      // decoded instruction, held from the end of q1 until q4
      arbc_pkg::arbc_op_t          op;
      logic                        dest;
      logic [arbc_pkg::BW-1:0]     bitpos;
      logic [arbc_pkg::AW-1:0]     addr;
      // operands captured at the end of q2
      logic [arbc_pkg::DW-1:0]     file_opnd;
      logic [arbc_pkg::DW-1:0]     acc_opnd;
      // registered copies of every output
      logic                        instr_ready;
      logic                        file_rd_en;
      logic [arbc_pkg::AW-1:0]     file_rd_addr;
      logic                        file_wr_en;
      logic [arbc_pkg::AW-1:0]     file_wr_addr;
      logic [arbc_pkg::DW-1:0]     file_wr_data;
      logic                        acc_wr_en;
      logic [arbc_pkg::DW-1:0]     acc_wr_data;
      logic                        zero_wr_en;
      logic                        zero_value;
   } arbc_state_t;

   arbc_state_t st_reg;
   arbc_state_t st_next;

   logic                    is_and;
   logic                    is_clr;
   logic [arbc_pkg::DW-1:0] and_result;
   logic [arbc_pkg::DW-1:0] clr_mask;
   logic [arbc_pkg::DW-1:0] clr_result;
   logic                    word_dest;
   logic [arbc_pkg::BW-1:0] word_bit;
   logic [arbc_pkg::AW-1:0] word_addr;
   logic                    take_word;

   // width of a bit position, used to size the per-bit mask compare
   typedef logic [arbc_pkg::BW-1:0] arbc_bitpos_t;

   // opcode match on the incoming word
   assign is_and = (instr_word[arbc_pkg::AND_OPC_MSB:arbc_pkg::AND_OPC_LSB]
                    == arbc_pkg::AND_OPC);
   assign is_clr = (instr_word[arbc_pkg::CLR_OPC_MSB:arbc_pkg::CLR_OPC_LSB]
                    == arbc_pkg::CLR_OPC);

   // operand fields of the incoming word; the bit field overlaps the and opcode
   // and destination bits, so it only means something once is_clr is known
   assign word_dest = instr_word[arbc_pkg::DEST_POS];
   assign word_bit  = instr_word[arbc_pkg::BIT_MSB:arbc_pkg::BIT_LSB];
   assign word_addr = instr_word[arbc_pkg::ADDR_MSB:arbc_pkg::ADDR_LSB];
   // a word is taken only when it is valid and one of the two patterns matches
   assign take_word = instr_valid && (is_and || is_clr);

   // datapath on the operands captured in q2
   assign and_result = st_reg.acc_opnd & st_reg.file_opnd;
   // one mask bit per data bit, low only at the selected position; a 3-bit
   // position always lands inside the byte, so there is no out-of-range case
   for (genvar i = 0; i < arbc_pkg::DW; i++) begin : g_clr_mask
      assign clr_mask[i] = (st_reg.bitpos != arbc_bitpos_t'(i));
   end
   assign clr_result = st_reg.file_opnd & clr_mask;

   // one pass of decode / read / process / write per instruction cycle
   always_comb begin
      st_next             = st_reg;
      // strobes are single-cycle, dropped unless a phase raises them
      st_next.file_rd_en  = 1'b0;
      st_next.file_wr_en  = 1'b0;
      st_next.acc_wr_en   = 1'b0;
      st_next.zero_wr_en  = 1'b0;
      // ready shows during q1, the only cycle a word is taken
      st_next.instr_ready = (ph.phase == arbc_pkg::ARBC_Q4);
      unique case (ph.phase)
         arbc_pkg::ARBC_Q1: begin
            // decode; unknown words become a silent no-op
            st_next.op     = arbc_pkg::ARBC_OP_NONE;
            st_next.dest   = word_dest;
            st_next.bitpos = word_bit;
            st_next.addr   = word_addr;
            if (instr_valid && is_and) begin
               st_next.op = arbc_pkg::ARBC_OP_AND;
            end else if (instr_valid && is_clr) begin
               st_next.op = arbc_pkg::ARBC_OP_CLR;
            end
            if (take_word) begin
               // address goes out now so the read happens in q2
               st_next.file_rd_en   = 1'b1;
               st_next.file_rd_addr = word_addr;
            end
         end
         arbc_pkg::ARBC_Q2: begin
            // read the file register and accumulator
            st_next.file_opnd = file_rd_data;
            st_next.acc_opnd  = acc_in;
         end
         arbc_pkg::ARBC_Q3: begin
            // process; results are registered so they appear during q4
            unique case (st_reg.op)
               arbc_pkg::ARBC_OP_NONE: begin
                  // nothing to process; the strobes stay low from the defaults
               end
               arbc_pkg::ARBC_OP_AND: begin
                  if (st_reg.dest == arbc_pkg::DEST_ACC) begin
                     st_next.acc_wr_en   = 1'b1;
                     st_next.acc_wr_data = and_result;
                  end else begin
                     st_next.file_wr_en   = 1'b1;
                     st_next.file_wr_addr = st_reg.addr;
                     st_next.file_wr_data = and_result;
                  end
                  // zero flag is the only status touched
                  st_next.zero_wr_en = 1'b1;
                  st_next.zero_value = (and_result == arbc_pkg::ZERO_BYTE);
               end
               arbc_pkg::ARBC_OP_CLR: begin
                  // no zero_wr_en here: flags stay as they are
                  st_next.file_wr_en   = 1'b1;
                  st_next.file_wr_addr = st_reg.addr;
                  st_next.file_wr_data = clr_result;
               end
               default: begin
                  // an illegal op code processes nothing and writes nothing
                  st_next.op = arbc_pkg::ARBC_OP_NONE;
               end
            endcase
         end
         arbc_pkg::ARBC_Q4: begin
            // write strobes are high this cycle; retire the instruction
            // a retired op cannot be replayed by a later q3 without a fresh decode
            st_next.op = arbc_pkg::ARBC_OP_NONE;
         end
         default: begin
            // an illegal phase code issues nothing; the sequencer returns to q1
            st_next.op = arbc_pkg::ARBC_OP_NONE;
         end
      endcase
   end

   // state register; every output is a field of it
   // reset clears every strobe so nothing is written while the core is held
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg.op           <= arbc_pkg::ARBC_OP_NONE;
         st_reg.dest         <= arbc_pkg::DEST_ACC;
         st_reg.bitpos       <= arbc_pkg::ZERO_BIT;
         st_reg.addr         <= arbc_pkg::ZERO_ADDR;
         st_reg.file_opnd    <= arbc_pkg::ZERO_BYTE;
         st_reg.acc_opnd     <= arbc_pkg::ZERO_BYTE;
         st_reg.instr_ready  <= 1'b0;
         st_reg.file_rd_en   <= 1'b0;
         st_reg.file_rd_addr <= arbc_pkg::ZERO_ADDR;
         st_reg.file_wr_en   <= 1'b0;
         st_reg.file_wr_addr <= arbc_pkg::ZERO_ADDR;
         st_reg.file_wr_data <= arbc_pkg::ZERO_BYTE;
         st_reg.acc_wr_en    <= 1'b0;
         st_reg.acc_wr_data  <= arbc_pkg::ZERO_BYTE;
         st_reg.zero_wr_en   <= 1'b0;
         st_reg.zero_value   <= 1'b0;
      end else begin
         st_reg <= st_next;
      end
   end

   // outputs straight from the state register
   // no combinational path runs from an input to a pin
   assign instr_ready  = st_reg.instr_ready;
   assign file_rd_en   = st_reg.file_rd_en;
   assign file_rd_addr = st_reg.file_rd_addr;
   assign file_wr_en   = st_reg.file_wr_en;
   assign file_wr_addr = st_reg.file_wr_addr;
   assign file_wr_data = st_reg.file_wr_data;
   assign acc_wr_en    = st_reg.acc_wr_en;
   assign acc_wr_data  = st_reg.acc_wr_data;
   assign zero_wr_en   = st_reg.zero_wr_en;
   assign zero_value   = st_reg.zero_value;
endmodule : arbc_exec
`default_nettype wire

// ===== core/arbc_phase_if.sv
// Purpose: carries the instruction-cycle phase from the sequencer to the executor
// Assumes: one phase per ref_clk cycle
// Notes:   phase is one-hot, q1..q4
`timescale 1ns/1ps
`default_nettype none
interface arbc_phase_if;
   arbc_pkg::arbc_phase_t phase;
   modport gen (output phase);
   modport use_p (input phase);
endinterface : arbc_phase_if
`default_nettype wire

// ===== core/arbc_pkg.sv
// Purpose: shared constants and types for the and/bit-clear execute block
// Assumes: 14-bit instruction words, 8-bit data, 7-bit file addresses
// Notes:   phase and op encodings are one-hot
package arbc_pkg;
   localparam int IW = 14;            // instruction word width
   localparam int DW = 8;             // data width
   localparam int AW = 7;             // file address width
   localparam int BW = 3;             // bit-position width

   // and_acc_with_reg: 00 0101 d fffffff
   localparam logic [5:0] AND_OPC     = 6'h05;
   localparam int         AND_OPC_MSB = 13;
   localparam int         AND_OPC_LSB = 8;
   localparam int         DEST_POS    = 7;
   localparam logic       DEST_ACC    = 1'b0;
   localparam logic       DEST_REG    = 1'b1;

   // single_bit_reset_op: 01 00 bbb fffffff
   localparam logic [3:0] CLR_OPC     = 4'h4;
   localparam int         CLR_OPC_MSB = 13;
   localparam int         CLR_OPC_LSB = 10;
   localparam int         BIT_MSB     = 9;
   localparam int         BIT_LSB     = 7;
   localparam int         ADDR_MSB    = 6;
   localparam int         ADDR_LSB    = 0;

   localparam logic [DW-1:0] ZERO_BYTE = 8'h00;
   localparam logic [DW-1:0] ONE_BYTE  = 8'h01;
   localparam logic [AW-1:0] ZERO_ADDR = 7'h00;
   localparam logic [BW-1:0] ZERO_BIT  = 3'h0;

   typedef enum logic [3:0] {
      ARBC_Q1 = 4'b0001,
      ARBC_Q2 = 4'b0010,
      ARBC_Q3 = 4'b0100,
      ARBC_Q4 = 4'b1000
   } arbc_phase_t;

   typedef enum logic [2:0] {
      ARBC_OP_NONE = 3'b001,
      ARBC_OP_AND  = 3'b010,
      ARBC_OP_CLR  = 3'b100
   } arbc_op_t;
endpackage : arbc_pkg

// ===== core/arbc_qphase.sv
// Purpose: four-phase instruction-cycle sequencer
// Assumes: each phase lasts one ref_clk cycle
// Notes:   starts in q1 from reset
`timescale 1ns/1ps
`default_nettype none
module arbc_qphase (
   input wire logic    ref_clk,
   input wire logic    reset_n,
   arbc_phase_if.gen   ph
);
   typedef struct packed {
      arbc_pkg::arbc_phase_t phase;
   } arbc_qstate_t;

   arbc_qstate_t st_reg;
   arbc_qstate_t st_next;

   // rotate q1 -> q2 -> q3 -> q4 -> q1
   always_comb begin
      st_next = st_reg;
      unique case (st_reg.phase)
         arbc_pkg::ARBC_Q1: st_next.phase = arbc_pkg::ARBC_Q2;
         arbc_pkg::ARBC_Q2: st_next.phase = arbc_pkg::ARBC_Q3;
         arbc_pkg::ARBC_Q3: st_next.phase = arbc_pkg::ARBC_Q4;
         arbc_pkg::ARBC_Q4: st_next.phase = arbc_pkg::ARBC_Q1;
         // an illegal one-hot code falls back to q1 rather than sticking
         default:           st_next.phase = arbc_pkg::ARBC_Q1;
      endcase
   end

   // state register
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         st_reg.phase <= arbc_pkg::ARBC_Q1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ph.phase = st_reg.phase;
endmodule : arbc_qphase
`default_nettype wire

// ===== dv/arbc_exec_properties.sv
// Purpose: port checks for the and/bit-clear executor
// Assumes: instr_ready marks q1, write strobes come three cycles later
// Notes:   bound onto arbc_exec
`timescale 1ns/1ps
`default_nettype none
module arbc_exec_chk (
   input wire logic                    ref_clk,
   input wire logic                    reset_n,
   input wire logic                    instr_valid,
   input wire logic [arbc_pkg::IW-1:0] instr_word,
   input wire logic [arbc_pkg::DW-1:0] acc_in,
   input wire logic [arbc_pkg::DW-1:0] file_rd_data,
   input wire logic                    instr_ready,
   input wire logic                    file_rd_en,
   input wire logic [arbc_pkg::AW-1:0] file_rd_addr,
   input wire logic                    file_wr_en,
   input wire logic [arbc_pkg::AW-1:0] file_wr_addr,
   input wire logic [arbc_pkg::DW-1:0] file_wr_data,
   input wire logic                    acc_wr_en,
   input wire logic [arbc_pkg::DW-1:0] acc_wr_data,
   input wire logic                    zero_wr_en,
   input wire logic                    zero_value
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   // decoded takes; operands are looked up with $past from the q2 cycle
   wire tk_and = instr_ready && instr_valid && instr_word[13:8] == arbc_pkg::AND_OPC;
   wire tk_clr = instr_ready && instr_valid && instr_word[13:10] == arbc_pkg::CLR_OPC;
   wire any_wr = file_wr_en || acc_wr_en || zero_wr_en;
   AST_RD_Q2: assert property ((tk_and || tk_clr) |=> file_rd_en
      && file_rd_addr == $past(instr_word[6:0])) else $error("no read in q2");
   AST_NOP: assert property (instr_ready && !(tk_and || tk_clr) |=>
      !file_rd_en ##2 !any_wr) else $error("strobe for unknown word");
   AST_AND_W: assert property (tk_and && !instr_word[7] |-> ##3 acc_wr_en
      && zero_wr_en && !file_wr_en && acc_wr_data == ($past(acc_in, 2)
      & $past(file_rd_data, 2))) else $error("and to acc wrong");
   AST_AND_F: assert property (tk_and && instr_word[7] |-> ##3 file_wr_en
      && zero_wr_en && !acc_wr_en && file_wr_addr == $past(instr_word[6:0], 3)
      && file_wr_data == ($past(acc_in, 2) & $past(file_rd_data, 2)))
      else $error("and to file wrong");
   AST_CLR: assert property (tk_clr |-> ##3 file_wr_en && !zero_wr_en
      && !acc_wr_en && file_wr_addr == $past(instr_word[6:0], 3)
      && file_wr_data == ($past(file_rd_data, 2)
      & ~(8'h01 << $past(instr_word[9:7], 3)))) else $error("bit clear wrong");
   AST_ZERO: assert property (zero_wr_en |-> zero_value ==
      ((acc_wr_en ? acc_wr_data : file_wr_data) == 8'h00)) else $error("zero flag wrong");
   AST_PERIOD: assert property (instr_ready |=> !instr_ready [*3] ##1 instr_ready)
      else $error("ready not every fourth cycle");
   AST_Q4: assert property (any_wr |=> instr_ready)
      else $error("write outside q4");
endmodule : arbc_exec_chk
bind arbc_exec arbc_exec_chk u_chk (.ref_clk, .reset_n, .instr_valid, .instr_word,
   .acc_in, .file_rd_data, .instr_ready, .file_rd_en, .file_rd_addr, .file_wr_en,
   .file_wr_addr, .file_wr_data, .acc_wr_en, .acc_wr_data, .zero_wr_en, .zero_value);
`default_nettype wire

// ===== dv/arbc_exec_tb_top.sv
// Purpose: self-checking bench for the and/bit-clear executor
// Assumes: bench plays file memory and accumulator, answering in q2
// Notes:   inputs change on the falling edge
`timescale 1ns/1ps
`default_nettype none
module arbc_exec_tb_top;
   logic        ref_clk, reset_n, instr_valid, instr_ready, file_rd_en;
   logic        file_wr_en, acc_wr_en, zero_wr_en, zero_value;
   logic [13:0] instr_word;
   logic [7:0]  acc_in, file_rd_data, file_wr_data, acc_wr_data;
   logic [6:0]  file_rd_addr, file_wr_addr;
   int          num_errors, tests_run, cyc;
   typedef struct {logic v; logic [13:0] w; logic [7:0] a, f; logic [2:0] en;
      logic [7:0] d; logic z;} arbc_row_t;
   // valid, word, acc, file, {acc,file,zero} strobes, written data, zero flag
   arbc_row_t rows [6] = '{
      '{1'b1, 14'h0512, 8'h17, 8'hC2, 3'b101, 8'h02, 1'b0},
      '{1'b1, 14'h05FF, 8'hF0, 8'h0F, 3'b011, 8'h00, 1'b1},
      '{1'b1, 14'h0500, 8'hFF, 8'h80, 3'b101, 8'h80, 1'b0},
      '{1'b1, 14'h1385, 8'h00, 8'hC7, 3'b010, 8'h47, 1'b0},
      '{1'b1, 14'h1485, 8'h00, 8'hC7, 3'b000, 8'h00, 1'b0},
      '{1'b0, 14'h0512, 8'h17, 8'hC2, 3'b000, 8'h00, 1'b0}};

   arbc_exec dut (.ref_clk, .reset_n, .instr_valid, .instr_word, .acc_in, .file_rd_data,
      .instr_ready, .file_rd_en, .file_rd_addr, .file_wr_en, .file_wr_addr,
      .file_wr_data, .acc_wr_en, .acc_wr_data, .zero_wr_en, .zero_value);

   initial begin
      ref_clk = 1'b0;
      forever #2.5 ref_clk = ~ref_clk;
   end

   // cut a hang short; the whole run needs about 85 cycles
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc > 2000) begin
         num_errors++;
         results();
      end
   end

   task automatic chk(input logic c, input string m);
      tests_run++;
      if (c !== 1'b1) begin
         num_errors++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk

   task automatic results;
      $display("errors %0d checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask : results

   // one instruction cycle: offer in q1, answer the read in q2, check q4
   task automatic run_op(input arbc_row_t r);
      logic rd;
      int   n;
      rd = r.en[2] | r.en[1];
      n = 0;
      while (instr_ready !== 1'b1 && n < 12) begin
         @(negedge ref_clk);
         n++;
      end
      chk(n < 12, "no ready");
      instr_valid = r.v;
      instr_word = r.w;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      chk(file_rd_en === rd && (!rd || file_rd_addr === r.w[6:0]), "read");
      file_rd_data = r.f;
      acc_in = r.a;
      @(negedge ref_clk);
      // read port released: show the inverse so stale data cannot pass
      file_rd_data = ~r.f;
      acc_in = ~r.a;
      @(negedge ref_clk);
      chk({acc_wr_en, file_wr_en, zero_wr_en} === r.en, "strobes");
      if (r.en[2]) chk(acc_wr_data === r.d, "acc data");
      if (r.en[1]) chk(file_wr_data === r.d && file_wr_addr === r.w[6:0], "file");
      if (r.en[0]) chk(zero_value === r.z, "zero flag");
      @(negedge ref_clk);
   endtask : run_op

   initial begin
      reset_n = 1'b0;
      instr_valid = 1'b0;
      instr_word = 14'h0000;
      acc_in = 8'h00;
      file_rd_data = 8'h00;
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      foreach (rows[i]) run_op(rows[i]);
      // every bit position, back to back, address at both ends of its range
      for (int b = 0; b < 8; b++) run_op('{1'b1, {4'h4, b[2:0], b[0] ? 7'h7F : 7'h00},
         8'h00, 8'hFF, 3'b010, ~(8'h01 << b), 1'b0});
      // reset in mid-instruction must drop every strobe at once
      while (instr_ready !== 1'b1) @(negedge ref_clk);
      instr_valid = 1'b1;
      instr_word = 14'h0512;
      @(negedge ref_clk);
      instr_valid = 1'b0;
      reset_n = 1'b0;
      #1;
      chk({instr_ready, file_rd_en, file_wr_en, acc_wr_en, zero_wr_en} === 5'h00, "rst");
      repeat (8) @(negedge ref_clk);
      reset_n = 1'b1;
      @(negedge ref_clk);
      chk(instr_ready === 1'b0 && file_wr_en === 1'b0, "after reset");
      run_op(rows[1]);
      results();
   end
endmodule : arbc_exec_tb_top
`default_nettype wire
